// *** hdl/light_load_holdoff.sv ***
// hold-off timer gating light-load entry after host reset release
// assumes host_reset_n_i is already synchronised to clk_i
`timescale 1ns/1ps
module light_load_holdoff #(
  parameter int HOLD_CYCLES = 1250000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic host_reset_n_i,
  output logic permit_o
);
  import mpc_pkg::*;
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

  typedef struct packed {
    logic prev;
    logic counting;
    logic [CW-1:0] cnt;
    logic permit;
  } hold_state_t;

  hold_state_t s_q, s_d;

  // restart on a rising edge seen while enabled, clear while host reset is low
  always_comb begin
    s_d = s_q;
    s_d.prev = host_reset_n_i;
    if (!enable_i || !host_reset_n_i) begin // [RULE11] [RULE18]
      s_d.counting = 1'b0;
      s_d.cnt = '0;
      s_d.permit = 1'b0;
    end else if (!s_q.prev) begin // [RULE13] [RULE18]
      s_d.counting = 1'b1;
      s_d.cnt = '0;
      s_d.permit = 1'b0;
    end else if (s_q.counting) begin
      if (s_q.cnt == LAST) begin
        s_d.counting = 1'b0;
        s_d.permit = 1'b1; // [RULE12]
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign permit_o = s_q.permit;
endmodule

// *** hdl/multiphase_power_state_control.sv ***
// multiphase buck controller: power state, regulator-good, channel pulses
// assumes pins are asynchronous to CLK_I; register port is on CLK_I
//
// Contract
// [RULE1] strapped third sense pin: two-phase only
// [RULE2] channels spaced one third period apart
// [RULE3] low side waits for high side off
// [RULE4] strap picks 5.75V or 7.75V in light-load
// [RULE5] good held low before soft-start ends
// [RULE6] good reports limits after post-start delay
// [RULE7] limits, overcurrent or disable pull good low
// [RULE8] good is open-drain, drives low only
// [RULE9] request high normal, low light-load
// [RULE10] request high again leaves light-load
// [RULE11] host reset low refuses light-load
// [RULE12] host reset high permits light-load entry; code permits only after a host reset rise seen while enabled
// [RULE13] 50ms wait after host reset rises
// [RULE14] soft-start or code move forces normal
// [RULE15] light-load diode-emulation keeps channel one only
// [RULE16] one rising edge per channel interval
// [RULE17] enable low stops all operation
// [RULE18] hold-off counter restarts and clears
`timescale 1ns/1ps
module multiphase_power_state_control #(
  parameter int HOLD_CYCLES = mpc_pkg::HOLDOFF_CYCLES,
  parameter int GOOD_DELAY_CYCLES = mpc_pkg::RG_DELAY_CYCLES,
  parameter bit DIODE_EMULATION_VARIANT = 1'b1
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // register port
  input wire logic [mpc_pkg::AW-1:0] ADDR_I,
  input wire logic [mpc_pkg::DW-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [mpc_pkg::DW-1:0] RDATA_O,
  // pins
  input wire logic ENABLE_I,
  input wire logic CH3_CURRENT_SENSE_NEG_AT_BIAS_I,
  input wire logic SOFT_START_STRAP_I,
  input wire logic POWER_STATE_REQUEST_N_I,
  input wire logic HOST_RESET_N_I,
  input wire logic VOLTAGE_IN_LIMITS_I,
  input wire logic OVERCURRENT_I,
  input wire logic SOFT_START_DONE_I,
  input wire logic VID_TRANSITION_I,
  input wire logic [mpc_pkg::NUM_CH-1:0] HIGH_SIDE_GATE_SENSE_I,
  output logic [mpc_pkg::NUM_CH-1:0] HIGH_SIDE_GATE_O,
  output logic [mpc_pkg::NUM_CH-1:0] LOW_SIDE_GATE_O,
  output logic CH1_LOW_DRIVER_SUPPLY_REDUCED_O,
  output logic CH1_LOW_DRIVER_SUPPLY_LEVEL_O,
  output logic LIGHT_LOAD_O,
  output logic DIODE_EMULATION_O,
  output logic REGULATOR_GOOD_O,
  output logic REGULATOR_GOOD_OE_O
);
  import mpc_pkg::*;
  localparam int GW = $clog2(GOOD_DELAY_CYCLES + 1);
  localparam logic [GW-1:0] GOOD_LAST = GW'(GOOD_DELAY_CYCLES - 1);

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    power_state_t ps;
    logic [TW-1:0] period;
    logic [TW-1:0] duty;
    logic [DW-1:0] rdata;
    logic [GW-1:0] good_cnt;
    logic good_wait_done;
    logic good;
    logic [NUM_CH-1:0] ch_en;
    logic [NUM_CH-1:0] hs;
    logic [NUM_CH-1:0] ls;
    logic supply_reduced;
    logic supply_level;
    logic diode_emulation;
    logic light;
    logic good_oe;
  } top_state_t;

  top_state_t s_q, s_d;

  logic permit;
  logic [NUM_CH-1:0] eng_hs;
  logic [NUM_CH-1:0] eng_ls;
  logic run;

  // synchronised pin views, read only from the second stage
  logic en;
  logic two_phase;
  logic ss_strap;
  logic psreq_n;
  logic host_rst_n;
  logic in_limits;
  logic overcurrent;
  logic ss_done;
  logic vid_move;
  logic [NUM_CH-1:0] hs_fb;

  assign en = s_q.sync2[SY_EN];
  assign two_phase = s_q.sync2[SY_TWO_PHASE];
  assign ss_strap = s_q.sync2[SY_SS_STRAP];
  assign psreq_n = s_q.sync2[SY_PSREQ_N];
  assign host_rst_n = s_q.sync2[SY_HOST_RST_N];
  assign in_limits = s_q.sync2[SY_IN_LIMITS];
  assign overcurrent = s_q.sync2[SY_OVERCURRENT];
  assign ss_done = s_q.sync2[SY_SS_DONE];
  assign vid_move = s_q.sync2[SY_VID_MOVE];
  assign hs_fb = s_q.sync2[SY_HS_FB +: NUM_CH];

  // outputs of the pulse engine are gated by enable downstream
  assign run = en && (s_q.ps != PS_OFF);

  // hold-off timer for light-load entry
  light_load_holdoff #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_holdoff (
    .clk_i(CLK_I),
    .rst_n_i(RESETN_I),
    .enable_i(en),
    .host_reset_n_i(host_rst_n),
    .permit_o(permit)
  );

  // interleaved pulse scheduling and gate interlock
  phase_engine #(
    .N(NUM_CH),
    .W(TW)
  ) u_engine (
    .clk_i(CLK_I),
    .rst_n_i(RESETN_I),
    .period_i(s_q.period),
    .duty_i(s_q.duty),
    .two_phase_i(two_phase),
    .ch_en_i(s_q.ch_en),
    .hs_fb_i(hs_fb),
    .hs_o(eng_hs),
    .ls_o(eng_ls)
  );

  always_comb begin
    logic forced_normal;
    logic enter_light;
    logic light_next;
    forced_normal = 1'b0;
    enter_light = 1'b0;
    light_next = 1'b0;
    s_d = s_q;

    // two-stage synchroniser for every pin input
    s_d.sync1 = {HIGH_SIDE_GATE_SENSE_I, VID_TRANSITION_I, SOFT_START_DONE_I, OVERCURRENT_I,
                 VOLTAGE_IN_LIMITS_I, HOST_RESET_N_I, POWER_STATE_REQUEST_N_I, SOFT_START_STRAP_I,
                 CH3_CURRENT_SENSE_NEG_AT_BIAS_I, ENABLE_I};
    s_d.sync2 = s_q.sync1;

    // register writes
    if (WR_I) begin
      case (ADDR_I)
        ADDR_PERIOD: s_d.period = WDATA_I[TW-1:0];
        ADDR_DUTY: s_d.duty = WDATA_I[TW-1:0];
        default: ;
      endcase
    end

    // register reads, data in the following cycle only
    s_d.rdata = '0;
    if (RD_I) begin
      case (ADDR_I)
        ADDR_PERIOD: s_d.rdata = {{(DW-TW){1'b0}}, s_q.period};
        ADDR_DUTY: s_d.rdata = {{(DW-TW){1'b0}}, s_q.duty};
        ADDR_STATUS: begin
          s_d.rdata[ST_LIGHT] = (s_q.ps == PS_LIGHT);
          s_d.rdata[ST_TWO_PHASE] = two_phase;
          s_d.rdata[ST_GOOD] = s_q.good;
          s_d.rdata[ST_SS_DONE] = ss_done;
          s_d.rdata[ST_PERMIT] = permit;
          s_d.rdata[ST_ENABLED] = en;
        end
        default: s_d.rdata = '0;
      endcase
    end

    // power state selection
    forced_normal = !ss_done || vid_move; // [RULE14]
    enter_light = !psreq_n && permit && !forced_normal; // [RULE9] [RULE11] [RULE12]
    case (s_q.ps)
      PS_OFF: begin
        if (en) s_d.ps = PS_NORMAL;
      end
      PS_NORMAL: begin
        if (!en) s_d.ps = PS_OFF; // [RULE17]
        else if (enter_light) s_d.ps = PS_LIGHT; // [RULE9]
      end
      PS_LIGHT: begin
        if (!en) s_d.ps = PS_OFF; // [RULE17]
        else if (psreq_n || forced_normal || !permit) s_d.ps = PS_NORMAL; // [RULE10] [RULE11] [RULE14]
      end
      default: s_d.ps = PS_OFF;
    endcase
    light_next = (s_d.ps == PS_LIGHT);
    s_d.light = light_next; // [RULE9]

    // channel enables: two-phase strap and light-load phase dropping
    s_d.ch_en[0] = en && (s_d.ps != PS_OFF);
    s_d.ch_en[1] = en && (s_d.ps != PS_OFF) && !light_next; // [RULE15]
    s_d.ch_en[2] = en && (s_d.ps != PS_OFF) && !light_next && !two_phase; // [RULE1] [RULE15]

    // gate outputs, all off when disabled
    s_d.hs = run ? eng_hs : '0; // [RULE17]
    s_d.ls = run ? eng_ls : '0; // [RULE17]
    if (two_phase) begin
      s_d.hs[2] = 1'b0; // [RULE1]
      s_d.ls[2] = 1'b0; // [RULE1]
    end

    // light-load driver options on the diode-emulation variant
    s_d.diode_emulation = DIODE_EMULATION_VARIANT && light_next;
    s_d.supply_reduced = DIODE_EMULATION_VARIANT && light_next; // [RULE4]
    s_d.supply_level = ss_strap ? SUPPLY_7V75 : SUPPLY_5V75; // [RULE4]

    // regulator-good delay counted from the end of soft-start
    if (!en || !ss_done) begin
      s_d.good_cnt = '0;
      s_d.good_wait_done = 1'b0; // [RULE5]
    end else if (!s_q.good_wait_done) begin
      if (s_q.good_cnt == GOOD_LAST) s_d.good_wait_done = 1'b1; // [RULE6]
      else s_d.good_cnt = s_q.good_cnt + 1'b1;
    end
    s_d.good = en && ss_done && s_q.good_wait_done && in_limits && !overcurrent; // [RULE6] [RULE7]
    // pull-down enable kept in its own flop so the pin has no gate after it
    s_d.good_oe = !s_d.good; // [RULE8]
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_q <= '0;
      s_q.ps <= PS_OFF;
      s_q.period <= PERIOD_RST;
      s_q.duty <= DUTY_RST;
      s_q.good_oe <= 1'b1; // line held low through reset
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state
  assign RDATA_O = s_q.rdata;
  assign HIGH_SIDE_GATE_O = s_q.hs;
  assign LOW_SIDE_GATE_O = s_q.ls;
  assign CH1_LOW_DRIVER_SUPPLY_REDUCED_O = s_q.supply_reduced;
  assign CH1_LOW_DRIVER_SUPPLY_LEVEL_O = s_q.supply_level;
  assign LIGHT_LOAD_O = s_q.light;
  assign DIODE_EMULATION_O = s_q.diode_emulation;
  // open-drain: drive low when not good, release otherwise
  assign REGULATOR_GOOD_O = 1'b0; // [RULE8]
  assign REGULATOR_GOOD_OE_O = s_q.good_oe; // [RULE8]
endmodule

// *** hdl/phase_engine.sv ***
// interleaved per-channel pulse scheduler with gate drive interlock
// assumes hs_fb_i is synchronised; period_i is at least 3
`timescale 1ns/1ps
module phase_engine #(
  parameter int N = 3,
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] period_i,
  input wire logic [W-1:0] duty_i,
  input wire logic two_phase_i,
  input wire logic [N-1:0] ch_en_i,
  input wire logic [N-1:0] hs_fb_i,
  output logic [N-1:0] hs_o,
  output logic [N-1:0] ls_o
);
  import mpc_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [N-1:0] fired;
    logic [N-1:0] hs;
    logic [N-1:0] ls;
  } eng_state_t;

  eng_state_t s_q, s_d;

  // position of cnt relative to a channel's start offset
  function automatic logic [W-1:0] wrap_sub(input logic [W-1:0] c, input logic [W-1:0] o,
                                            input logic [W-1:0] p);
    wrap_sub = (c >= o) ? c - o : c + p - o;
  endfunction

  // start offset: thirds of the period, halves in two-phase mode
  function automatic logic [W-1:0] ch_offset(input int k, input logic [W-1:0] p, input logic two);
    logic [W-1:0] third;
    third = p / 3;
    if (k == 0) ch_offset = '0;
    else if (two) ch_offset = p >> 1;
    else ch_offset = (k == 1) ? third : W'(third << 1);
  endfunction

  always_comb begin
    logic [W-1:0] pos;
    logic req;
    logic rise;
    pos = '0;
    req = 1'b0;
    rise = 1'b0;
    s_d = s_q;
    // free-running interval timer
    s_d.cnt = (s_q.cnt >= period_i - 1'b1) ? '0 : s_q.cnt + 1'b1;
    for (int k = 0; k < N; k++) begin
      pos = wrap_sub(s_q.cnt, ch_offset(k, period_i, two_phase_i), period_i); // [RULE2]
      req = ch_en_i[k] && (pos < duty_i);
      // one rising edge per interval, only after low side is off
      rise = req && !s_q.hs[k] && !s_q.ls[k] && ((pos == '0) || !s_q.fired[k]); // [RULE16]
      s_d.fired[k] = (pos == '0) ? rise : (s_q.fired[k] || rise); // [RULE16]
      s_d.hs[k] = req && (s_q.hs[k] || rise);
      // low side only while high side gate is seen off
      s_d.ls[k] = ch_en_i[k] && !req && !s_q.hs[k] && !hs_fb_i[k]; // [RULE3]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hs_o = s_q.hs;
  assign ls_o = s_q.ls;
endmodule

// *** pkg/mpc_pkg.sv ***
// constants shared by the multiphase power-state controller
// assumes a single 25 MHz core clock
package mpc_pkg;
  // core clock
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  // light-load hold-off after host reset release
  localparam int HOLDOFF_MS = 50;
  localparam int HOLDOFF_CYCLES = HOLDOFF_MS * CLK_PER_MS;
  // regulator-good delay after soft-start ends
  localparam int RG_DELAY_US = 100;
  localparam int RG_DELAY_CYCLES = RG_DELAY_US * CLK_PER_US;
  // channels and timer width
  localparam int NUM_CH = 3;
  localparam int TW = 16;
  // register port
  localparam int AW = 4;
  localparam int DW = 32;
  localparam logic [AW-1:0] ADDR_PERIOD = 4'h0;
  localparam logic [AW-1:0] ADDR_DUTY = 4'h4;
  localparam logic [AW-1:0] ADDR_STATUS = 4'h8;
  localparam logic [TW-1:0] PERIOD_RST = 16'h00FA;
  localparam logic [TW-1:0] DUTY_RST = 16'h0000;
  // status field positions
  localparam int ST_LIGHT = 0;
  localparam int ST_TWO_PHASE = 1;
  localparam int ST_GOOD = 2;
  localparam int ST_SS_DONE = 3;
  localparam int ST_PERMIT = 4;
  localparam int ST_ENABLED = 5;
  // channel-1 low driver supply level codes
  localparam logic SUPPLY_5V75 = 1'b0;
  localparam logic SUPPLY_7V75 = 1'b1;
  // synchronised pin vector layout
  localparam int SY_EN = 0;
  localparam int SY_TWO_PHASE = 1;
  localparam int SY_SS_STRAP = 2;
  localparam int SY_PSREQ_N = 3;
  localparam int SY_HOST_RST_N = 4;
  localparam int SY_IN_LIMITS = 5;
  localparam int SY_OVERCURRENT = 6;
  localparam int SY_SS_DONE = 7;
  localparam int SY_VID_MOVE = 8;
  localparam int SY_HS_FB = 9;
  localparam int SY_W = 12;
  // power state encoding
  typedef enum logic [2:0] {
    PS_OFF = 3'b001,
    PS_NORMAL = 3'b010,
    PS_LIGHT = 3'b100
  } power_state_t;
endpackage

// *** verification/host_power_model.sv ***
// host side: drives power-state request and host reset lines
// assumes the bench steers it with two level controls
`timescale 1ns/1ps
module host_power_model (
  input wire logic clk_i,
  input wire logic want_light_i,
  input wire logic in_reset_i,
  output logic power_state_request_n_o,
  output logic host_reset_n_o
);
  // start in reset with normal state asked for
  initial begin
    power_state_request_n_o = 1'b1;
    host_reset_n_o = 1'b0;
  end
  // lines change just after the edge, like a registered host
  always @(posedge clk_i) begin
    power_state_request_n_o <= !want_light_i;
    host_reset_n_o <= !in_reset_i;
  end
endmodule

// *** verification/mpsc_checker_asserts.sv ***
// concurrent checks on the top ports of the multiphase controller
// assumes one clock CLK_I and asynchronous active-low RESETN_I
`timescale 1ns/1ps
module mpsc_checker #(
  parameter int HOLD_CYCLES = 20,
  parameter int GOOD_DELAY_CYCLES = 5
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic ENABLE_I,
  input wire logic CH3_CURRENT_SENSE_NEG_AT_BIAS_I,
  input wire logic POWER_STATE_REQUEST_N_I,
  input wire logic HOST_RESET_N_I,
  input wire logic OVERCURRENT_I,
  input wire logic SOFT_START_DONE_I,
  input wire logic VID_TRANSITION_I,
  input wire logic [mpc_pkg::NUM_CH-1:0] HIGH_SIDE_GATE_O,
  input wire logic [mpc_pkg::NUM_CH-1:0] LOW_SIDE_GATE_O,
  input wire logic LIGHT_LOAD_O,
  input wire logic REGULATOR_GOOD_O,
  input wire logic REGULATOR_GOOD_OE_O
);
  import mpc_pkg::*;
  int hold_q;
  // cycles the host reset line has stood high
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hold_q <= 0;
    end else if (!HOST_RESET_N_I) begin
      hold_q <= 0;
    end else if (hold_q < HOLD_CYCLES) begin
      hold_q <= hold_q + 1;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // input latencies: two sync stages, state edge, gate edge
  chk_ch3_idle: assert property (CH3_CURRENT_SENSE_NEG_AT_BIAS_I [*6] |-> !HIGH_SIDE_GATE_O[2])
    else $error("third channel fired in two-phase mode");
  chk_no_shoot: assert property ((HIGH_SIDE_GATE_O & LOW_SIDE_GATE_O) == '0)
    else $error("high and low side on together");
  chk_good_early: assert property (!SOFT_START_DONE_I [*5] |-> REGULATOR_GOOD_OE_O)
    else $error("good released before soft-start end");
  chk_good_delay: assert property ($fell(REGULATOR_GOOD_OE_O) |-> $past(SOFT_START_DONE_I, GOOD_DELAY_CYCLES))
    else $error("good released before delay ran out");
  chk_good_fault: assert property ((OVERCURRENT_I || !ENABLE_I) [*5] |-> REGULATOR_GOOD_OE_O)
    else $error("good not pulled low on fault");
  chk_good_drain: assert property (REGULATOR_GOOD_O == 1'b0)
    else $error("good line driven high");
  chk_req_normal: assert property (POWER_STATE_REQUEST_N_I [*5] |-> !LIGHT_LOAD_O)
    else $error("light load without request");
  chk_host_block: assert property (!HOST_RESET_N_I [*5] |-> !LIGHT_LOAD_O)
    else $error("light load during host reset");
  chk_hold_off: assert property ($rose(LIGHT_LOAD_O) |-> hold_q >= HOLD_CYCLES)
    else $error("light load entered inside hold-off");
  chk_seq_force: assert property ((VID_TRANSITION_I || !SOFT_START_DONE_I) [*5] |-> !LIGHT_LOAD_O)
    else $error("light load during start or code move");
  chk_light_ch1: assert property (LIGHT_LOAD_O [*3] |-> HIGH_SIDE_GATE_O[2:1] == 2'b00)
    else $error("channels two or three fired in light load");
  chk_disable_stop: assert property (!ENABLE_I [*6] |-> HIGH_SIDE_GATE_O == '0 && !LIGHT_LOAD_O)
    else $error("activity while disabled");
  cov_light: cover property ($rose(LIGHT_LOAD_O));
  cov_good: cover property ($fell(REGULATOR_GOOD_OE_O));
  cov_ch3: cover property ($rose(HIGH_SIDE_GATE_O[2]));
endmodule

bind multiphase_power_state_control mpsc_checker #(.HOLD_CYCLES(HOLD_CYCLES),
  .GOOD_DELAY_CYCLES(GOOD_DELAY_CYCLES)) mpsc_checker_i (.*);

// *** verification/multiphase_power_state_control_tb_top.sv ***
// testbench for the multiphase controller: registers, good, phases, power state
// assumes the checker is bound to the top and the host model drives its lines
`timescale 1ns/1ps
module multiphase_power_state_control_tb_top;
  import mpc_pkg::*;
  localparam int HOLD = 20;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, en = 1'b0, strap3 = 1'b0, ss_strap = 1'b1;
  logic lim = 1'b1, oc = 1'b0, ssd = 1'b0, vid = 1'b0, want = 1'b0, inrst = 1'b1, psreq_n, hrst_n;
  logic red, lvl, light, diode_emulation, good, good_oe;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0, rdata;
  logic [NUM_CH-1:0] hs_sense = '0, hs, ls;
  int fails = 0, check_count = 0, cyc_n = 0, d1, d2;
  multiphase_power_state_control #(.HOLD_CYCLES(HOLD), .GOOD_DELAY_CYCLES(5)) multiphase_power_state_control_i (
    .CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .ENABLE_I(en), .CH3_CURRENT_SENSE_NEG_AT_BIAS_I(strap3), .SOFT_START_STRAP_I(ss_strap),
    .POWER_STATE_REQUEST_N_I(psreq_n), .HOST_RESET_N_I(hrst_n), .VOLTAGE_IN_LIMITS_I(lim),
    .OVERCURRENT_I(oc), .SOFT_START_DONE_I(ssd), .VID_TRANSITION_I(vid), .HIGH_SIDE_GATE_SENSE_I(hs_sense),
    .HIGH_SIDE_GATE_O(hs), .LOW_SIDE_GATE_O(ls), .CH1_LOW_DRIVER_SUPPLY_REDUCED_O(red),
    .CH1_LOW_DRIVER_SUPPLY_LEVEL_O(lvl), .LIGHT_LOAD_O(light), .DIODE_EMULATION_O(diode_emulation),
    .REGULATOR_GOOD_O(good), .REGULATOR_GOOD_OE_O(good_oe));
  host_power_model host_power_model_i (.clk_i(clk), .want_light_i(want), .in_reset_i(inrst),
    .power_state_request_n_o(psreq_n), .host_reset_n_o(hrst_n));
  // clock, cycle count and gate feedback
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    hs_sense <= hs;
  end
  task automatic results();
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(logic [AW-1:0] a, logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(string name, logic [AW-1:0] a, logic [DW-1:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(name, e, rdata);
  endtask
  // cycles from a channel one rise to the next rises of channels two and three
  task automatic phases(output int r1, output int r2);
    int c;
    logic [2:0] p;
    r1 = -1;
    r2 = -1;
    c = -1;
    p = hs;
    repeat (100) begin
      @(posedge clk);
      #1;
      if (c >= 0) c++;
      else if (hs[0] && !p[0]) c = 0;
      if (c > 0 && c <= 30 && hs[1] && !p[1] && r1 < 0) r1 = c;
      if (c > 0 && c <= 30 && hs[2] && !p[2] && r2 < 0) r2 = c;
      p = hs;
    end
  endtask
  // watchdog well beyond the expected run
  initial begin
    #(40 * 5000);
    fails++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("period", ADDR_PERIOD, {16'h0000, PERIOD_RST});
    rd_chk("duty", ADDR_DUTY, {16'h0000, DUTY_RST});
    rd_chk("unmapped", 4'hC, 32'h0000_0000);
    wr_reg(ADDR_PERIOD, 32'h0000_001E);
    wr_reg(ADDR_DUTY, 32'h0000_000A);
    rd_chk("period", ADDR_PERIOD, 32'h0000_001E);
    @(posedge clk);
    en <= 1'b1;
    cyc(10);
    chk("good before start", 1, good_oe);
    @(posedge clk);
    ssd <= 1'b1;
    cyc(4);
    chk("good inside delay", 1, good_oe);
    cyc(10);
    chk("good", 0, good_oe);
    lim <= 1'b0;
    cyc(5);
    chk("good out of limits", 1, good_oe);
    lim <= 1'b1;
    oc <= 1'b1;
    cyc(5);
    chk("good overcurrent", 1, good_oe);
    oc <= 1'b0;
    cyc(15);
    chk("good back", 0, good_oe);
    phases(d1, d2);
    chk("ch2 lag", 10, d1);
    chk("ch3 lag", 20, d2);
    strap3 <= 1'b1;
    cyc(10);
    phases(d1, d2);
    chk("two-phase ch2 lag", 15, d1);
    chk("two-phase ch3", -1, d2);
    strap3 <= 1'b0;
    want <= 1'b1;
    cyc(10);
    chk("light in host reset", 0, light);
    inrst <= 1'b0;
    cyc(HOLD / 2);
    chk("light in hold-off", 0, light);
    cyc(HOLD);
    chk("light", 1, light);
    chk("supply level", SUPPLY_7V75, lvl);
    chk("supply reduced", 1, red);
    chk("diode emulation", 1, diode_emulation);
    rd_chk("status", ADDR_STATUS, 32'h0000_003D);
    phases(d1, d2);
    chk("light ch2", -1, d1);
    vid <= 1'b1;
    cyc(6);
    chk("light in code move", 0, light);
    vid <= 1'b0;
    cyc(6);
    chk("light after code move", 1, light);
    want <= 1'b0;
    cyc(6);
    chk("light after request", 0, light);
    en <= 1'b0;
    cyc(8);
    chk("gates disabled", 0, {hs, ls});
    chk("good disabled", 1, good_oe);
    results();
  end
endmodule
